// ===== shared/rcu_pkg.sv
package rcu_pkg;
    // clock and microsecond step
    localparam int unsigned CLK_FREQ_HZ   = 100_000_000;
    localparam int unsigned STEP_TIME_US  = 1;
    localparam int unsigned CYC_PER_STEP  = (CLK_FREQ_HZ / 1_000_000) * STEP_TIME_US;

    // timed outputs: five front-end outputs then six radio event timers
    localparam int unsigned NUM_FE        = 5;
    localparam int unsigned NUM_EVT       = 6;
    localparam int unsigned NUM_TMR       = NUM_FE + NUM_EVT;
    localparam int unsigned NUM_SEL       = 4;
    localparam int unsigned DLY_W         = 8;

    // pin function identifiers of the front-end outputs
    localparam logic [5:0]  PFID_FE_FIRST = 6'h37;   // 55
    localparam logic [5:0]  PFID_FE_LAST  = 6'h3B;   // 59

    // register byte offsets
    localparam logic [7:0]  OFS_TMR_CTRL0 = 8'h00;   // ctrl of timer i at 8*i
    localparam logic [7:0]  OFS_TMR_DLY0  = 8'h04;   // delays of timer i at 8*i+4
    localparam logic [7:0]  OFS_TMR_STEP  = 8'h08;
    localparam logic [7:0]  OFS_SEL_A     = 8'h60;   // diag_selector_pair_a
    localparam logic [7:0]  OFS_SEL_B     = 8'h64;   // diag_selector_pair_b
    localparam logic [7:0]  OFS_IRQ_STAT  = 8'h68;
    localparam logic [7:0]  OFS_IRQ_MASK  = 8'h6C;
    localparam logic [7:0]  OFS_OUT_STAT  = 8'h70;

    // field positions
    localparam int unsigned POS_CTRL_SET  = 0;       // [1:0] set reference edge
    localparam int unsigned POS_CTRL_CLR  = 2;       // [3:2] clear reference edge
    localparam int unsigned POS_CTRL_EN   = 4;       // [4] timer enable
    localparam int unsigned POS_DLY_SET   = 0;       // [7:0] set delay in us
    localparam int unsigned POS_DLY_CLR   = 8;       // [15:8] clear delay in us
    localparam int unsigned SEL_W         = 8;       // one selector per byte

    // reset values
    localparam logic [15:0] RST_REG16     = 16'h0000;
    localparam logic [3:0]  RST_IRQ4      = 4'h0;

    // reference edges of the transmit and receive windows
    typedef enum logic [1:0] {
        RCU_EDGE_TX_RISE = 2'b00,
        RCU_EDGE_TX_FALL = 2'b01,
        RCU_EDGE_RX_RISE = 2'b10,
        RCU_EDGE_RX_FALL = 2'b11
    } rcu_edge_e;

    // timer configuration
    typedef struct packed {
        logic             en;
        rcu_edge_e        clr_edge;
        rcu_edge_e        set_edge;
        logic [DLY_W-1:0] clr_dly;
        logic [DLY_W-1:0] set_dly;
    } rcu_tmr_cfg_s;

    // one diagnostic selector, byte layout {en, 2'b0, bsel, wsel}
    typedef struct packed {
        logic       en;
        logic [1:0] unused;
        logic [2:0] bsel;
        logic [1:0] wsel;
    } rcu_sel_s;

    // window edge events of one cycle
    typedef struct packed {
        logic rx_fall;
        logic rx_rise;
        logic tx_fall;
        logic tx_rise;
    } rcu_edges_s;
endpackage : rcu_pkg

// ===== rtl/rcu_radio_control_unit.sv
`timescale 1ns/100ps
module rcu_radio_control_unit
    import rcu_pkg::*;
#(
    parameter int unsigned CLK_HZ = rcu_pkg::CLK_FREQ_HZ,
    parameter int unsigned DLY_BITS = rcu_pkg::DLY_W
)
(
    // clock and reset
    input  wire logic                    clk_sys,
    input  wire logic                    rst,
    // apb slave
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [7:0]              paddr,
    input  wire logic [31:0]             pwdata,
    output logic                         pready,
    output logic                         pslverr,
    output logic [31:0]                  prdata,
    // direct mac side
    input  wire logic                    tx_window,
    input  wire logic                    rx_window,
    input  wire logic [7:0]              mac_diag_bit,
    // timed outputs
    output logic [rcu_pkg::NUM_FE-1:0]   timed_frontend_output,
    output logic [rcu_pkg::NUM_EVT-1:0]  radio_event_timer,
    // pin multiplexer slice
    input  wire logic [5:0]              pin_function_id,
    output logic                         pin_func_out,
    // interrupt
    output logic                         radio_diag_interrupt
);
    import rcu_pkg::*;

    // refuse settings the logic cannot serve
    if (CLK_HZ < 1_000_000 || (CLK_HZ % 1_000_000) != 0)
        $error("clock must be a whole number of MHz");
    if (DLY_BITS != DLY_W)
        $error("delay width must match the 8-bit register fields");

    localparam int unsigned STEP_CYC = (CLK_HZ / 1_000_000) * STEP_TIME_US;
    localparam int unsigned PRE_W    = (STEP_CYC > 1) ? $clog2(STEP_CYC) : 1;
    localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(STEP_CYC - 1);

    // picks the event of the chosen reference edge
    function automatic logic edge_pick(input rcu_edges_s ev, input rcu_edge_e sel);
        logic r;
        r = 1'b0;
        case (sel)
            RCU_EDGE_TX_RISE: r = ev.tx_rise;
            RCU_EDGE_TX_FALL: r = ev.tx_fall;
            RCU_EDGE_RX_RISE: r = ev.rx_rise;
            RCU_EDGE_RX_FALL: r = ev.rx_fall;
            default:          r = 1'b0;
        endcase
        return r;
    endfunction : edge_pick

    // source selection of one diagnostic selector
    function automatic logic diag_pick(input rcu_sel_s s, input logic [7:0] mac, input logic [7:0] radio);
        logic r;
        r = 1'b0;
        if (s.en)
        begin
            if (s.wsel[1])
                r = radio[s.bsel];
            else
                r = mac[s.bsel];
        end
        return r;
    endfunction : diag_pick

    // register storage
    logic [15:0]         tmr_ctrl_reg [NUM_TMR];
    logic [15:0]         tmr_dly_reg  [NUM_TMR];
    logic [15:0]         sel_a_reg;
    logic [15:0]         sel_b_reg;
    logic [3:0]          irq_stat_reg;
    logic [3:0]          irq_mask_reg;
    logic [31:0]         prdata_reg;
    logic                tx_prev_reg;
    logic                rx_prev_reg;
    logic [PRE_W-1:0]    pre_reg;
    logic [NUM_TMR-1:0]  out_reg;
    logic [NUM_SEL-1:0]  src_prev_reg;

    // bus decode
    logic                acc;
    logic                setup;
    logic                wr;
    logic                is_tmr;
    logic [3:0]          tmr_idx;
    logic                hit;
    logic [31:0]         rd_word;
    logic [15:0]         rd_tmr;
    assign acc     = psel & penable;
    assign setup   = psel & ~penable;
    assign wr      = acc & pwrite & ~pslverr;
    assign tmr_idx = paddr[6:3];
    assign is_tmr  = (paddr < 8'(NUM_TMR * OFS_TMR_STEP)) && (paddr[1:0] == 2'b00);
    assign hit     = is_tmr
                   || paddr == OFS_SEL_A || paddr == OFS_SEL_B
                   || paddr == OFS_IRQ_STAT || paddr == OFS_IRQ_MASK
                   || paddr == OFS_OUT_STAT;
    assign pready  = 1'b1;
    assign pslverr = acc & ~hit;
    assign prdata  = prdata_reg;
    assign rd_tmr  = paddr[2] ? tmr_dly_reg[tmr_idx] : tmr_ctrl_reg[tmr_idx];

    // read mux, upper half reads zero
    always_comb
    begin
        rd_word = 32'h0000_0000;
        if (is_tmr)
            rd_word = {16'h0000, rd_tmr};
        else if (paddr == OFS_SEL_A)
            rd_word = {16'h0000, sel_a_reg};
        else if (paddr == OFS_SEL_B)
            rd_word = {16'h0000, sel_b_reg};
        else if (paddr == OFS_IRQ_STAT)
            rd_word = {28'h000_0000, irq_stat_reg};
        else if (paddr == OFS_IRQ_MASK)
            rd_word = {28'h000_0000, irq_mask_reg};
        else if (paddr == OFS_OUT_STAT)
            rd_word = {21'h00_0000, out_reg};
        else
            rd_word = 32'h0000_0000;
    end

    // read data captured in the setup cycle
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            prdata_reg <= 32'h0000_0000;
        else if (setup && !pwrite)
            prdata_reg <= rd_word;
    end

    // timer register writes, low half only
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            for (int i = 0; i < NUM_TMR; i++)
            begin
                tmr_ctrl_reg[i] <= RST_REG16;
                tmr_dly_reg[i]  <= RST_REG16;
            end
        end
        else if (wr && is_tmr)
        begin
            if (paddr[2])
                tmr_dly_reg[tmr_idx]  <= pwdata[15:0];
            else
                tmr_ctrl_reg[tmr_idx] <= pwdata[15:0];
        end
    end

    // selector and mask writes
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            sel_a_reg    <= RST_REG16;
            sel_b_reg    <= RST_REG16;
            irq_mask_reg <= RST_IRQ4;
        end
        else if (wr)
        begin
            if (paddr == OFS_SEL_A)
                sel_a_reg <= pwdata[15:0];
            if (paddr == OFS_SEL_B)
                sel_b_reg <= pwdata[15:0];
            if (paddr == OFS_IRQ_MASK)
                irq_mask_reg <= pwdata[3:0];
        end
    end

    // window edge detection
    rcu_edges_s ev;
    assign ev.tx_rise = tx_window & ~tx_prev_reg;
    assign ev.tx_fall = ~tx_window & tx_prev_reg;
    assign ev.rx_rise = rx_window & ~rx_prev_reg;
    assign ev.rx_fall = ~rx_window & rx_prev_reg;

    // microsecond step
    logic step;
    assign step = (pre_reg == PRE_LAST);

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            tx_prev_reg <= 1'b0;
            rx_prev_reg <= 1'b0;
            pre_reg     <= '0;
        end
        else
        begin
            tx_prev_reg <= tx_window;
            rx_prev_reg <= rx_window;
            pre_reg     <= step ? '0 : PRE_W'(pre_reg + 1'b1);
        end
    end

    // eleven identical timers: five front-end then six event timers
    for (genvar t = 0; t < NUM_TMR; t++)
    begin : g_tmr
        rcu_tmr_cfg_s       cfg;
        logic               set_ev;
        logic               clr_ev;
        logic               set_now;
        logic               clr_now;
        logic               set_pend_reg;
        logic               clr_pend_reg;
        logic [DLY_W-1:0]   set_cnt_reg;
        logic [DLY_W-1:0]   clr_cnt_reg;
        logic               out_next;

        assign cfg = {tmr_ctrl_reg[t][POS_CTRL_EN],
                      rcu_edge_e'(tmr_ctrl_reg[t][POS_CTRL_CLR +: 2]),
                      rcu_edge_e'(tmr_ctrl_reg[t][POS_CTRL_SET +: 2]),
                      tmr_dly_reg[t][POS_DLY_CLR +: DLY_W],
                      tmr_dly_reg[t][POS_DLY_SET +: DLY_W]};
        assign set_ev = cfg.en & edge_pick(ev, cfg.set_edge);
        assign clr_ev = cfg.en & edge_pick(ev, cfg.clr_edge);
        // zero delay acts at the edge, else on the last step of the count
        assign set_now = (set_ev && cfg.set_dly == '0)
                       || (set_pend_reg && step && set_cnt_reg == DLY_W'(1));
        assign clr_now = (clr_ev && cfg.clr_dly == '0)
                       || (clr_pend_reg && step && clr_cnt_reg == DLY_W'(1));
        // clear wins a tie; disabling drops the output
        assign out_next = !cfg.en ? 1'b0 : clr_now ? 1'b0 : set_now ? 1'b1 : out_reg[t];

        always_ff @(posedge clk_sys)
        begin
            if (rst)
            begin
                set_pend_reg <= 1'b0;
                set_cnt_reg  <= '0;
                out_reg[t]   <= 1'b0;
            end
            else
            begin
                out_reg[t] <= out_next;
                if (set_ev)
                begin
                    set_pend_reg <= (cfg.set_dly != '0);
                    set_cnt_reg  <= cfg.set_dly;
                end
                else if (!cfg.en)
                    set_pend_reg <= 1'b0;   // no stale count across a disable
                else if (set_pend_reg && step)
                begin
                    set_pend_reg <= (set_cnt_reg != DLY_W'(1));
                    set_cnt_reg  <= DLY_W'(set_cnt_reg - 1'b1);
                end
            end
        end

        always_ff @(posedge clk_sys)
        begin
            if (rst)
            begin
                clr_pend_reg <= 1'b0;
                clr_cnt_reg  <= '0;
            end
            else if (clr_ev)
            begin
                clr_pend_reg <= (cfg.clr_dly != '0);
                clr_cnt_reg  <= cfg.clr_dly;
            end
            else if (!cfg.en)
                clr_pend_reg <= 1'b0;
            else if (clr_pend_reg && step)
            begin
                clr_pend_reg <= (clr_cnt_reg != DLY_W'(1));
                clr_cnt_reg  <= DLY_W'(clr_cnt_reg - 1'b1);
            end
        end
    end

    // timed outputs leave straight from flip-flops
    assign timed_frontend_output = out_reg[NUM_FE-1:0];
    assign radio_event_timer     = out_reg[NUM_TMR-1:NUM_FE];

    // pin multiplexer slice for identifiers 55..59
    logic       pf_hit;
    logic [5:0] pf_ofs;
    assign pf_hit       = (pin_function_id >= PFID_FE_FIRST) && (pin_function_id <= PFID_FE_LAST);
    assign pf_ofs       = 6'(pin_function_id - PFID_FE_FIRST);
    assign pin_func_out = pf_hit ? out_reg[pf_ofs[2:0]] : 1'b0;

    // radio source word: windows on 7 and 6, event timers on 5..0
    logic [7:0]         radio_word;
    rcu_sel_s           sel [NUM_SEL];
    logic [NUM_SEL-1:0] src;
    logic [NUM_SEL-1:0] src_rise;
    assign radio_word = {tx_window, rx_window, out_reg[NUM_TMR-1:NUM_FE]};
    assign sel[0]     = rcu_sel_s'(sel_a_reg[0 +: SEL_W]);
    assign sel[1]     = rcu_sel_s'(sel_a_reg[SEL_W +: SEL_W]);
    assign sel[2]     = rcu_sel_s'(sel_b_reg[0 +: SEL_W]);
    assign sel[3]     = rcu_sel_s'(sel_b_reg[SEL_W +: SEL_W]);
    for (genvar s = 0; s < NUM_SEL; s++)
    begin : g_sel
        assign src[s] = diag_pick(sel[s], mac_diag_bit, radio_word);
    end
    assign src_rise = src & ~src_prev_reg;

    // sticky status, set wins over write-one-to-clear
    logic [3:0] stat_clr;
    assign stat_clr = (wr && paddr == OFS_IRQ_STAT) ? pwdata[3:0] : 4'h0;

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            src_prev_reg <= '0;
            irq_stat_reg <= RST_IRQ4;
        end
        else
        begin
            src_prev_reg <= src;
            irq_stat_reg <= (irq_stat_reg & ~stat_clr) | src_rise;
        end
    end

    // level interrupt while any unmasked status bit stands
    assign radio_diag_interrupt = |(irq_stat_reg & irq_mask_reg);

endmodule : rcu_radio_control_unit

// ===== sim/rcu_radio_control_unit_monitor.sv
`timescale 1ns/100ps
// watches reset, bus answers, pin mux and interrupt hold at the unit's ports
module rcu_radio_control_unit_monitor (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // register bus
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic        pready,
    input  wire logic        pslverr,
    input  wire logic [31:0] prdata,
    // outputs and pin function id
    input  wire logic [4:0]  timed_frontend_output,
    input  wire logic [5:0]  radio_event_timer,
    input  wire logic [5:0]  pin_function_id,
    input  wire logic        pin_func_out,
    input  wire logic        radio_diag_interrupt
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    // access phase, address decode and pin id decode
    wire       acc     = psel && penable;
    wire       aligned = paddr[1:0] == 2'h0;
    wire       mapped  = aligned && (paddr <= 8'h54 || paddr inside {8'h60, 8'h64, 8'h68, 8'h6C, 8'h70});
    wire       pin_hit = pin_function_id >= 6'h37 && pin_function_id <= 6'h3B;
    wire [5:0] pin_idx = pin_function_id - 6'h37;
    sequence s_rst;
        rst;
    endsequence
    sequence s_irq_quiet;
        radio_diag_interrupt && !(acc && pwrite);
    endsequence

    AST_RESET: assert property (disable iff (1'b0) s_rst |=>
        timed_frontend_output == 5'h00 && radio_event_timer == 6'h00 && !radio_diag_interrupt)
        else $error("reset left an output high");
    AST_READY: assert property (acc |-> pready)
        else $error("no ready in access phase");
    AST_UPPER: assert property (acc && !pwrite |-> prdata[31:16] == 16'h0000)
        else $error("read data upper half not zero");
    AST_PIN_SEL: assert property (pin_hit |-> pin_func_out == timed_frontend_output[pin_idx])
        else $error("pin mux shows wrong output");
    AST_PIN_OFF: assert property (!pin_hit |-> !pin_func_out)
        else $error("pin mux active for foreign id");
    AST_ERR_PHASE: assert property (pslverr |-> acc)
        else $error("error outside access phase");
    AST_MAPPED: assert property (acc && mapped |-> !pslverr)
        else $error("error on a mapped register");
    AST_UNMAPPED: assert property (acc && aligned && !mapped |-> pslverr && (pwrite || prdata == 32'h0000_0000))
        else $error("unmapped word not refused");
    AST_IRQ_HOLD: assert property (s_irq_quiet |=> radio_diag_interrupt)
        else $error("interrupt dropped without a write");
endmodule : rcu_radio_control_unit_monitor

bind rcu_radio_control_unit rcu_radio_control_unit_monitor u_monitor (.clk_sys, .rst, .psel, .penable, .pwrite,
    .paddr, .pready, .pslverr, .prdata, .timed_frontend_output, .radio_event_timer, .pin_function_id,
    .pin_func_out, .radio_diag_interrupt);

// ===== sim/rcu_mac_model.sv
`timescale 1ns/100ps
// mac side: transmit and receive windows and the diagnostic bus
module rcu_mac_model (
    // clock
    input  wire logic  clk_sys,
    // direct lines into the unit
    output logic       tx_window,
    output logic       rx_window,
    output logic [7:0] mac_diag_bit
);
    // quiet lines from time zero
    initial
    begin
        tx_window    = 1'b0;
        rx_window    = 1'b0;
        mac_diag_bit = 8'h00;
    end

    // moves all lines just after the next edge, then holds them
    task automatic set_lines(input logic tx, input logic rx, input logic [7:0] diag);
        @(posedge clk_sys);
        tx_window    <= tx;
        rx_window    <= rx;
        mac_diag_bit <= diag;
    endtask : set_lines
endmodule : rcu_mac_model

// ===== sim/rcu_radio_control_unit_bench.sv
`timescale 1ns/100ps
module rcu_radio_control_unit_bench;
    import rcu_pkg::*;
    // stimulus and observed lines
    logic        clk_sys         = 1'b0;
    logic        rst             = 1'b1;
    logic        psel            = 1'b0;
    logic        penable         = 1'b0;
    logic        pwrite          = 1'b0;
    logic [7:0]  paddr           = 8'h00;
    logic [31:0] pwdata          = 32'h0000_0000;
    logic [5:0]  pin_function_id = 6'h37;
    logic [31:0] rdat;
    logic        rerr;
    wire         pready, pslverr, pin_func_out, radio_diag_interrupt, tx_window, rx_window;
    wire  [31:0] prdata;
    wire  [7:0]  mac_diag_bit;
    wire  [4:0]  timed_frontend_output;
    wire  [5:0]  radio_event_timer;
    int          fail_count      = 0;
    int          samples_checked = 0;
    int          cycle_count     = 0;

    // 100 MHz clock
    always #5 clk_sys = ~clk_sys;

    rcu_radio_control_unit dut (.clk_sys, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
        .prdata, .tx_window, .rx_window, .mac_diag_bit, .timed_frontend_output, .radio_event_timer,
        .pin_function_id, .pin_func_out, .radio_diag_interrupt);
    rcu_mac_model mac (.clk_sys, .tx_window, .rx_window, .mac_diag_bit);

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : finish_test

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // one whole-word transfer: setup, access until ready
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do
        begin
            @(posedge clk_sys);
        end
        while (pready !== 1'b1);
        rdat    = prdata;
        rerr    = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string name);
        apb(1'b0, a, 32'h0000_0000);
        chk(name, exp, rdat);
    endtask : rd

    // quiet state after reset
    task automatic t_reset();
        chk("outputs", 32'h0, {20'h0, radio_event_timer, timed_frontend_output, radio_diag_interrupt});
        rd(OFS_OUT_STAT, 32'h0000_0000, "out state");
        rd(OFS_SEL_A, 32'h0000_0000, "sel a");
        rd(OFS_IRQ_STAT, 32'h0000_0000, "irq stat");
    endtask : t_reset

    // halfword registers, unmapped word, read-only state
    task automatic t_bus();
        apb(1'b1, OFS_TMR_DLY0, 32'hFFFF_5A3C);
        rd(OFS_TMR_DLY0, 32'h0000_5A3C, "dly0");
        apb(1'b1, 8'h58, 32'h0000_FFFF);
        chk("err write", 32'h1, {31'h0, rerr});
        rd(8'h58, 32'h0000_0000, "unmapped");
        apb(1'b1, OFS_OUT_STAT, 32'h0000_07FF);
        rd(OFS_OUT_STAT, 32'h0000_0000, "ro state");
        apb(1'b1, OFS_TMR_DLY0, 32'h0000_0000);
    endtask : t_bus

    // zero delay output on transmit window, seen through the pin mux
    task automatic t_fe_zero();
        apb(1'b1, OFS_TMR_CTRL0, 32'h0000_0014);
        mac.set_lines(1'b1, 1'b0, 8'h00);
        repeat (3) @(posedge clk_sys);
        chk("fe0 on", 32'h1, {31'h0, timed_frontend_output[0]});
        chk("pin 55", 32'h1, {31'h0, pin_func_out});
        pin_function_id <= 6'h3B;
        @(posedge clk_sys);
        chk("pin 59", 32'h0, {31'h0, pin_func_out});
        pin_function_id <= 6'h37;
        mac.set_lines(1'b0, 1'b0, 8'h00);
        repeat (3) @(posedge clk_sys);
        chk("fe0 off", 32'h0, {31'h0, timed_frontend_output[0]});
    endtask : t_fe_zero

    // three microsecond set delay from receive rise
    task automatic t_fe_delay();
        int n;
        apb(1'b1, OFS_TMR_CTRL0 + OFS_TMR_STEP, 32'h0000_001E);
        apb(1'b1, OFS_TMR_DLY0 + OFS_TMR_STEP, 32'h0000_0003);
        mac.set_lines(1'b0, 1'b1, 8'h00);
        n = 0;
        while (timed_frontend_output[1] !== 1'b1 && n < 400)
        begin
            @(posedge clk_sys);
            n++;
        end
        chk("fe1 delay", 32'h1, {31'h0, n >= 200 && n <= 303});
        mac.set_lines(1'b0, 1'b0, 8'h00);
        repeat (3) @(posedge clk_sys);
        chk("fe1 off", 32'h0, {31'h0, timed_frontend_output[1]});
    endtask : t_fe_delay

    // set on transmit fall, clear two microseconds after receive rise, then disable
    task automatic t_fe_fall();
        apb(1'b1, OFS_TMR_CTRL0 + 8'h10, 32'h0000_0019);
        apb(1'b1, OFS_TMR_DLY0 + 8'h10, 32'h0000_0200);
        mac.set_lines(1'b1, 1'b0, 8'h00);
        mac.set_lines(1'b0, 1'b0, 8'h00);
        repeat (3) @(posedge clk_sys);
        chk("fe2 tx fall", 32'h1, {31'h0, timed_frontend_output[2]});
        mac.set_lines(1'b0, 1'b1, 8'h00);
        repeat (90) @(posedge clk_sys);
        chk("fe2 held", 32'h1, {31'h0, timed_frontend_output[2]});
        repeat (120) @(posedge clk_sys);
        chk("fe2 clr delay", 32'h0, {31'h0, timed_frontend_output[2]});
        mac.set_lines(1'b1, 1'b0, 8'h00);
        mac.set_lines(1'b0, 1'b0, 8'h00);
        repeat (3) @(posedge clk_sys);
        chk("fe2 set again", 32'h1, {31'h0, timed_frontend_output[2]});
        apb(1'b1, OFS_TMR_CTRL0 + 8'h10, 32'h0000_0009);
        repeat (2) @(posedge clk_sys);
        chk("fe2 disabled", 32'h0, {31'h0, timed_frontend_output[2]});
    endtask : t_fe_fall

    // first event timer (timer 5 at 0x28) as source of selector two
    task automatic t_event();
        apb(1'b1, 8'h28, 32'h0000_0014);
        apb(1'b1, OFS_SEL_B, 32'h0000_0082);
        apb(1'b1, OFS_IRQ_MASK, 32'h0000_0004);
        mac.set_lines(1'b1, 1'b0, 8'h00);
        repeat (5) @(posedge clk_sys);
        chk("evt first", 32'h1, {26'h0, radio_event_timer});
        chk("evt irq", 32'h1, {31'h0, radio_diag_interrupt});
        mac.set_lines(1'b0, 1'b0, 8'h00);
        apb(1'b1, 8'h28, 32'h0000_0000);
        apb(1'b1, OFS_IRQ_STAT, 32'h0000_0004);
        rd(OFS_IRQ_STAT, 32'h0000_0000, "stat clr");
    endtask : t_event

    // four selectors on mac bits and both windows in turn, then mask and clear
    task automatic t_diag();
        apb(1'b1, OFS_SEL_A, 32'h0000_8994);
        apb(1'b1, OFS_SEL_B, 32'h0000_9B9E);
        apb(1'b1, OFS_IRQ_MASK, 32'h0000_000F);
        for (int k = 0; k < 4; k++)
        begin
            mac.set_lines(k == 2, k == 3, k == 0 ? 8'h20 : (k == 1 ? 8'h04 : 8'h00));
            repeat (3) @(posedge clk_sys);
            rd(OFS_IRQ_STAT, (32'h1 << (k + 1)) - 32'h1, "stat");
        end
        chk("irq on", 32'h1, {31'h0, radio_diag_interrupt});
        apb(1'b1, OFS_IRQ_MASK, 32'h0000_0000);
        @(posedge clk_sys);
        chk("irq masked", 32'h0, {31'h0, radio_diag_interrupt});
        apb(1'b1, OFS_IRQ_STAT, 32'h0000_0005);
        rd(OFS_IRQ_STAT, 32'h0000_000A, "w1c");
        mac.set_lines(1'b0, 1'b0, 8'h00);
    endtask : t_diag

    // hang guard
    always @(posedge clk_sys)
    begin
        cycle_count++;
        if (cycle_count == 5000)
        begin
            fail_count++;
            finish_test();
        end
    end

    // main sequence
    initial
    begin
        repeat (20) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        t_reset();
        t_bus();
        t_fe_zero();
        t_fe_delay();
        t_fe_fall();
        t_event();
        t_diag();
        finish_test();
    end
endmodule : rcu_radio_control_unit_bench
